/* periph_irq_flags.sv */
// peripheral request flag registers three and four with irq status
// assumes event inputs are synchronous to clk_i, one register port
`timescale 1ns/100ps

module periph_irq_flags (
  input  wire logic                               clk_i,
  input  wire logic                               reset_i,
  input  wire irq_flags_pkg::bus_req_type         bus_i,
  input  wire irq_flags_pkg::periph_events_type   events_i,
  output logic [irq_flags_pkg::DATA_W-1:0]        rdata_o,
  output logic [irq_flags_pkg::DATA_W-1:0]        flags_three_o,
  output logic [irq_flags_pkg::DATA_W-1:0]        flags_four_o,
  output logic                                    irq_o
);

  localparam int unsigned DW = irq_flags_pkg::DATA_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DW-1:0] mask_three;
    logic [DW-1:0] mask_four;
    logic [3:0]    capcmp_mode;
    logic [3:0]    cell_edge;
    logic          cell1_prev;
    logic          cell2_prev;
    logic [DW-1:0] rdata;
    logic          irq;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic [DW-1:0] set_three;
  logic [DW-1:0] set_four;
  logic [DW-1:0] flags_three;
  logic [DW-1:0] flags_four;
  logic [DW-1:0] status_three;
  logic [DW-1:0] status_four;
  logic          wr_three;
  logic          wr_four;
  logic          clr_status_three;
  logic          clr_status_four;
  logic          cell1_hit;
  logic          cell2_hit;
  logic          cell1_rise;
  logic          cell1_fall;
  logic          cell2_rise;
  logic          cell2_fall;
  logic [DW-1:0] pending_three;
  logic [DW-1:0] pending_four;
  logic [DW-1:0] read_word;
  logic          capcmp1_hit;
  logic          capcmp2_hit;
  irq_flags_pkg::capcmp_mode_type mode1;
  irq_flags_pkg::capcmp_mode_type mode2;

  // ----------------------------------------------------------------
  // unit event select
  // ----------------------------------------------------------------
  function automatic logic capcmp_select(
    input irq_flags_pkg::capcmp_mode_type mode,
    input logic                           capture,
    input logic                           compare,
    input logic                           pwm_edge
  );
    logic hit;
    hit = 1'b0;
    case (mode)
      irq_flags_pkg::MODE_CAPTURE: begin
        hit = capture;
      end
      irq_flags_pkg::MODE_COMPARE: begin
        hit = compare;
      end
      irq_flags_pkg::MODE_PWM: begin
        hit = pwm_edge;
      end
      irq_flags_pkg::MODE_OFF: begin
        hit = 1'b0;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : capcmp_select

  // ----------------------------------------------------------------
  // unit mode fields
  // ----------------------------------------------------------------
  always_comb begin
    mode1 = irq_flags_pkg::capcmp_mode_type'(
      state_q.capcmp_mode[irq_flags_pkg::CAPCMP1_MODE_LSB +: 2]);
    mode2 = irq_flags_pkg::capcmp_mode_type'(
      state_q.capcmp_mode[irq_flags_pkg::CAPCMP2_MODE_LSB +: 2]);
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  always_comb begin
    // edges against last cycle
    cell1_rise = events_i.logic_cell1_output & ~state_q.cell1_prev;
    cell1_fall = ~events_i.logic_cell1_output & state_q.cell1_prev;
    cell2_rise = events_i.logic_cell2_output & ~state_q.cell2_prev;
    cell2_fall = ~events_i.logic_cell2_output & state_q.cell2_prev;
    cell1_hit =
      (cell1_rise & state_q.cell_edge[irq_flags_pkg::CELL1_RISE_BIT]) |
      (cell1_fall & state_q.cell_edge[irq_flags_pkg::CELL1_FALL_BIT]);
    cell2_hit =
      (cell2_rise & state_q.cell_edge[irq_flags_pkg::CELL2_RISE_BIT]) |
      (cell2_fall & state_q.cell_edge[irq_flags_pkg::CELL2_FALL_BIT]);
    capcmp1_hit = capcmp_select(mode1, events_i.capcmp1_capture,
                                events_i.capcmp1_compare,
                                events_i.capcmp1_pwm_edge);
    capcmp2_hit = capcmp_select(mode2, events_i.capcmp2_capture,
                                events_i.capcmp2_compare,
                                events_i.capcmp2_pwm_edge);
  end

  // ----------------------------------------------------------------
  // set vectors
  // ----------------------------------------------------------------
  always_comb begin
    set_three = irq_flags_pkg::ZERO_BYTE;
    set_four  = irq_flags_pkg::ZERO_BYTE;
    set_three[irq_flags_pkg::OSC_FAILSAFE_BIT] = events_i.osc_fail;
    set_three[irq_flags_pkg::CLOCK_SWITCH_BIT] = events_i.clock_switch_done;
    set_three[irq_flags_pkg::LOGIC_CELL2_BIT]  = cell2_hit;
    set_three[irq_flags_pkg::LOGIC_CELL1_BIT]  = cell1_hit;
    set_four[irq_flags_pkg::WAVEFORM_BIT]      = events_i.waveform_shutdown;
    set_four[irq_flags_pkg::CAPCMP2_BIT]       = capcmp2_hit;
    set_four[irq_flags_pkg::CAPCMP1_BIT]       = capcmp1_hit;
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_three = bus_i.wr & (bus_i.addr == irq_flags_pkg::FLAGS_THREE_OFS);
    wr_four  = bus_i.wr & (bus_i.addr == irq_flags_pkg::FLAGS_FOUR_OFS);
    clr_status_three =
      bus_i.rd & (bus_i.addr == irq_flags_pkg::STATUS_THREE_OFS);
    clr_status_four =
      bus_i.rd & (bus_i.addr == irq_flags_pkg::STATUS_FOUR_OFS);
  end

  // ----------------------------------------------------------------
  // request flag banks
  // ----------------------------------------------------------------
  // software write, hardware set
  flag_bank #(
    .WIDTH     (DW),
    .IMPL_MASK (irq_flags_pkg::THREE_IMPL_MASK)
  ) flags_three_bank (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .set_i     (set_three),
    .wr_i      (wr_three),
    .wr_data_i (bus_i.wdata),
    .rd_clr_i  (1'b0),
    .q_o       (flags_three)
  );

  flag_bank #(
    .WIDTH     (DW),
    .IMPL_MASK (irq_flags_pkg::FOUR_IMPL_MASK)
  ) flags_four_bank (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .set_i     (set_four),
    .wr_i      (wr_four),
    .wr_data_i (bus_i.wdata),
    .rd_clr_i  (1'b0),
    .q_o       (flags_four)
  );

  // ----------------------------------------------------------------
  // interrupt status banks, cleared by read
  // ----------------------------------------------------------------
  flag_bank #(
    .WIDTH     (DW),
    .IMPL_MASK (irq_flags_pkg::THREE_IMPL_MASK)
  ) status_three_bank (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .set_i     (set_three),
    .wr_i      (1'b0),
    .wr_data_i (irq_flags_pkg::ZERO_BYTE),
    .rd_clr_i  (clr_status_three),
    .q_o       (status_three)
  );

  flag_bank #(
    .WIDTH     (DW),
    .IMPL_MASK (irq_flags_pkg::FOUR_IMPL_MASK)
  ) status_four_bank (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .set_i     (set_four),
    .wr_i      (1'b0),
    .wr_data_i (irq_flags_pkg::ZERO_BYTE),
    .rd_clr_i  (clr_status_four),
    .q_o       (status_four)
  );

  // ----------------------------------------------------------------
  // unmasked pending status
  // ----------------------------------------------------------------
  always_comb begin
    pending_three = status_three & state_q.mask_three;
    pending_four  = status_four & state_q.mask_four;
  end

  // ----------------------------------------------------------------
  // read word select
  // ----------------------------------------------------------------
  always_comb begin
    read_word = irq_flags_pkg::ZERO_BYTE;
    case (bus_i.addr)
      irq_flags_pkg::FLAGS_THREE_OFS: begin
        read_word = flags_three & irq_flags_pkg::THREE_IMPL_MASK;
      end
      irq_flags_pkg::FLAGS_FOUR_OFS: begin
        read_word = flags_four & irq_flags_pkg::FOUR_IMPL_MASK;
      end
      irq_flags_pkg::STATUS_THREE_OFS: begin
        read_word = status_three;
      end
      irq_flags_pkg::STATUS_FOUR_OFS: begin
        read_word = status_four;
      end
      irq_flags_pkg::MASK_THREE_OFS: begin
        read_word = state_q.mask_three;
      end
      irq_flags_pkg::MASK_FOUR_OFS: begin
        read_word = state_q.mask_four;
      end
      irq_flags_pkg::CAPCMP_MODE_OFS: begin
        read_word = {4'h0, state_q.capcmp_mode};
      end
      irq_flags_pkg::CELL_EDGE_OFS: begin
        read_word = {4'h0, state_q.cell_edge};
      end
      default: begin
        read_word = irq_flags_pkg::ZERO_BYTE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d            = state_q;
    state_d.cell1_prev = events_i.logic_cell1_output;
    state_d.cell2_prev = events_i.logic_cell2_output;
    state_d.rdata      = irq_flags_pkg::ZERO_BYTE;

    if (bus_i.wr) begin
      case (bus_i.addr)
        // flags are written inside their banks
        irq_flags_pkg::FLAGS_THREE_OFS,
        irq_flags_pkg::FLAGS_FOUR_OFS: begin
        end
        // status registers are read only
        irq_flags_pkg::STATUS_THREE_OFS,
        irq_flags_pkg::STATUS_FOUR_OFS: begin
        end
        irq_flags_pkg::MASK_THREE_OFS: begin
          state_d.mask_three = bus_i.wdata & irq_flags_pkg::THREE_IMPL_MASK;
        end
        irq_flags_pkg::MASK_FOUR_OFS: begin
          state_d.mask_four = bus_i.wdata & irq_flags_pkg::FOUR_IMPL_MASK;
        end
        irq_flags_pkg::CAPCMP_MODE_OFS: begin
          state_d.capcmp_mode = bus_i.wdata[3:0];
        end
        irq_flags_pkg::CELL_EDGE_OFS: begin
          state_d.cell_edge = bus_i.wdata[3:0];
        end
        default: begin
          state_d.capcmp_mode = state_q.capcmp_mode;
        end
      endcase
    end

    if (bus_i.rd) begin
      state_d.rdata = read_word;
    end

    // level irq from unmasked status
    state_d.irq = (pending_three != irq_flags_pkg::ZERO_BYTE) |
                  (pending_four != irq_flags_pkg::ZERO_BYTE);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q.mask_three  <= irq_flags_pkg::MASK_RESET;
      state_q.mask_four   <= irq_flags_pkg::MASK_RESET;
      state_q.capcmp_mode <= irq_flags_pkg::CAPCMP_MODE_RESET;
      state_q.cell_edge   <= irq_flags_pkg::CELL_EDGE_RESET;
      state_q.cell1_prev  <= 1'b0;
      state_q.cell2_prev  <= 1'b0;
      state_q.rdata       <= irq_flags_pkg::ZERO_BYTE;
      state_q.irq         <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o       = state_q.rdata;
  assign flags_three_o = flags_three;
  assign flags_four_o  = flags_four;
  assign irq_o         = state_q.irq;

endmodule : periph_irq_flags

/* irq_flags_pkg.sv */
// constants, field layouts and carriers of the peripheral request flag block
// assumes one system clock and a plain strobe register port
package irq_flags_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FLAGS_THREE_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] FLAGS_FOUR_OFS  = 4'h1;
  localparam logic [ADDR_W-1:0] STATUS_THREE_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_FOUR_OFS  = 4'h3;
  localparam logic [ADDR_W-1:0] MASK_THREE_OFS   = 4'h4;
  localparam logic [ADDR_W-1:0] MASK_FOUR_OFS    = 4'h5;
  localparam logic [ADDR_W-1:0] CAPCMP_MODE_OFS  = 4'h6;
  localparam logic [ADDR_W-1:0] CELL_EDGE_OFS    = 4'h7;

  // ----------------------------------------------------------------
  // bit positions, request register three
  // ----------------------------------------------------------------
  localparam int unsigned OSC_FAILSAFE_BIT = 7;
  localparam int unsigned CLOCK_SWITCH_BIT = 6;
  localparam int unsigned LOGIC_CELL2_BIT  = 1;
  localparam int unsigned LOGIC_CELL1_BIT  = 0;

  // ----------------------------------------------------------------
  // bit positions, request register four
  // ----------------------------------------------------------------
  localparam int unsigned WAVEFORM_BIT = 6;
  localparam int unsigned CAPCMP2_BIT  = 1;
  localparam int unsigned CAPCMP1_BIT  = 0;

  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] THREE_IMPL_MASK = 8'hC3;
  localparam logic [DATA_W-1:0] FOUR_IMPL_MASK  = 8'h43;
  localparam logic [DATA_W-1:0] FLAGS_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RESET      = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE       = 8'h00;

  // ----------------------------------------------------------------
  // unit mode field and logic cell edge field
  // ----------------------------------------------------------------
  localparam int unsigned CAPCMP1_MODE_LSB = 0;
  localparam int unsigned CAPCMP2_MODE_LSB = 2;
  localparam logic [3:0]  CAPCMP_MODE_RESET = 4'h0;
  localparam int unsigned CELL1_RISE_BIT   = 0;
  localparam int unsigned CELL1_FALL_BIT   = 1;
  localparam int unsigned CELL2_RISE_BIT   = 2;
  localparam int unsigned CELL2_FALL_BIT   = 3;
  localparam logic [3:0]  CELL_EDGE_RESET  = 4'h5;

  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_COMPARE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_OFF     = 2'b11
  } capcmp_mode_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic osc_fail;
    logic clock_switch_done;
    logic logic_cell1_output;
    logic logic_cell2_output;
    logic waveform_shutdown;
    logic capcmp1_capture;
    logic capcmp1_compare;
    logic capcmp1_pwm_edge;
    logic capcmp2_capture;
    logic capcmp2_compare;
    logic capcmp2_pwm_edge;
  } periph_events_type;

endpackage : irq_flags_pkg

/* flag_bank.sv */
// a bank of sticky flags: hardware sets, software writes or read clears
// assumes set pulses and strobes come from the same clock
`timescale 1ns/100ps

module flag_bank #(
  parameter int unsigned             WIDTH     = 8,
  parameter logic [WIDTH-1:0]        IMPL_MASK = 8'hFF
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic             wr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_clr_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } state_type;

  state_type state_q;
  state_type state_d;

  // ----------------------------------------------------------------
  // next state: set wins over write and clear
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (wr_i) begin
      state_d.flags = wr_data_i;
    end else if (rd_clr_i) begin
      state_d.flags = '0;
    end
    state_d.flags = (state_d.flags | set_i) & IMPL_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign q_o = state_q.flags;

endmodule : flag_bank

/* periph_irq_flags_props.sv */
// checker of the request flag block, ports of the top module only
// assumes one clock, synchronous active high reset
`timescale 1ns/100ps

module periph_irq_flags_checker (
  input  wire logic                               clk_i,
  input  wire logic                               reset_i,
  input  wire irq_flags_pkg::bus_req_type         bus_i,
  input  wire irq_flags_pkg::periph_events_type   events_i,
  input  wire logic [irq_flags_pkg::DATA_W-1:0]   rdata_o,
  input  wire logic [irq_flags_pkg::DATA_W-1:0]   flags_three_o,
  input  wire logic [irq_flags_pkg::DATA_W-1:0]   flags_four_o,
  input  wire logic                               irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ----------------------------------------------------------------
  // unit one mode and cell edge shadows
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic [3:0] edge_q;
  logic [3:0] edge_d;
  logic       hit_one;

  always_comb begin
    mode_d = mode_q;
    if (bus_i.wr && bus_i.addr == irq_flags_pkg::CAPCMP_MODE_OFS) begin
      mode_d = bus_i.wdata[1:0];
    end
    edge_d = edge_q;
    if (bus_i.wr && bus_i.addr == irq_flags_pkg::CELL_EDGE_OFS) begin
      edge_d = bus_i.wdata[3:0];
    end
    hit_one = (mode_q == 2'h0 && events_i.capcmp1_capture)
            || (mode_q == 2'h1 && events_i.capcmp1_compare)
            || (mode_q == 2'h2 && events_i.capcmp1_pwm_edge);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_q <= 2'h0;
      edge_q <= irq_flags_pkg::CELL_EDGE_RESET;
    end else begin
      mode_q <= mode_d;
      edge_q <= edge_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_cell2_sets: assert property (($rose(events_i.logic_cell2_output) && edge_q[2])
      || ($fell(events_i.logic_cell2_output) && edge_q[3]) |=> flags_three_o[1])
    else $error("cell two edge did not set its flag");
  a_cell1_sets: assert property (($rose(events_i.logic_cell1_output) && edge_q[0])
      || ($fell(events_i.logic_cell1_output) && edge_q[1]) |=> flags_three_o[0])
    else $error("cell one edge did not set its flag");
  a_wave_sets: assert property (events_i.waveform_shutdown |=> flags_four_o[6])
    else $error("shutdown did not set its flag");
  a_wave_stays_zero: assert property (!flags_four_o[6] && !events_i.waveform_shutdown
      && !(bus_i.wr && bus_i.addr == irq_flags_pkg::FLAGS_FOUR_OFS) |=> !flags_four_o[6])
    else $error("shutdown flag rose without cause");
  a_unimpl_zero: assert property ((flags_three_o & ~irq_flags_pkg::THREE_IMPL_MASK) == 8'h00
      && (flags_four_o & ~irq_flags_pkg::FOUR_IMPL_MASK) == 8'h00)
    else $error("unimplemented bit set");
  a_read_flags: assert property (bus_i.rd && bus_i.addr == irq_flags_pkg::FLAGS_THREE_OFS
      |=> rdata_o == $past(flags_three_o))
    else $error("read data differs from flags");
  a_write_four: assert property (bus_i.wr && bus_i.addr == irq_flags_pkg::FLAGS_FOUR_OFS
      && events_i == '0 |=> flags_four_o == ($past(bus_i.wdata) & irq_flags_pkg::FOUR_IMPL_MASK))
    else $error("flag write not applied");
  a_reset_clears: assert property (disable iff (1'b0) reset_i
      |=> flags_three_o == 8'h00 && flags_four_o == 8'h00 && !irq_o)
    else $error("reset left a flag set");
  a_osc_sets: assert property (events_i.osc_fail |=> flags_three_o[7])
    else $error("oscillator failure did not set its flag");
  a_switch_sets: assert property (events_i.clock_switch_done |=> flags_three_o[6])
    else $error("clock switch did not set its flag");
  a_capcmp_sets: assert property (hit_one |=> flags_four_o[0])
    else $error("unit event did not set its flag");

  c_shutdown: cover property (events_i.waveform_shutdown);
  c_status_read: cover property (bus_i.rd && bus_i.addr == irq_flags_pkg::STATUS_FOUR_OFS);
  c_irq: cover property ($rose(irq_o));
  c_cell_fall: cover property ($fell(events_i.logic_cell1_output) && edge_q[1]);
endmodule : periph_irq_flags_checker

bind periph_irq_flags periph_irq_flags_checker periph_irq_flags_checker_i (
  .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .events_i(events_i), .rdata_o(rdata_o),
  .flags_three_o(flags_three_o), .flags_four_o(flags_four_o), .irq_o(irq_o));

/* periph_events_model.sv */
// model of the peripherals that raise request events
// assumes the bench asks for events one cycle ahead
`timescale 1ns/100ps

module periph_events_model (
  input  wire logic                               clk_i,
  input  wire logic                               reset_i,
  input  wire irq_flags_pkg::periph_events_type   request_i,
  output irq_flags_pkg::periph_events_type        events_o
);
  // events launched one cycle after the request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      events_o <= '0;
    end else begin
      events_o <= request_i;
    end
  end
endmodule : periph_events_model

/* tb_top.sv */
// self-checking bench of the request flag block
// assumes the events model in front of the event port
`timescale 1ns/100ps

module tb_top;
  logic                               clk_i;
  logic                               reset_i;
  irq_flags_pkg::bus_req_type         bus_q;
  irq_flags_pkg::periph_events_type   request_q;
  irq_flags_pkg::periph_events_type   events;
  logic [7:0]                         rdata;
  logic [7:0]                         flags_three;
  logic [7:0]                         flags_four;
  logic                               irq;
  int                                 num_errors;
  int                                 check_count;
  int                                 cycles;

  periph_events_model periph_events_model_i (.clk_i(clk_i), .reset_i(reset_i),
    .request_i(request_q), .events_o(events));
  periph_irq_flags periph_irq_flags_i (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_q),
    .events_i(events), .rdata_o(rdata), .flags_three_o(flags_three),
    .flags_four_o(flags_four), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_q <= '0;
    @(posedge clk_i);
    #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    bus_q <= '0;
    #1;
    check8(rdata, exp);
    @(posedge clk_i);
    #1;
  endtask : rd_chk

  task automatic fire(input irq_flags_pkg::periph_events_type e);
    @(posedge clk_i);
    request_q <= e;
    @(posedge clk_i);
    request_q <= '0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : fire

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    for (int a = 0; a < 10; a++) begin
      rd_chk(a[3:0], (a == 7) ? 8'h05 : 8'h00);
    end
    check8({7'h00, irq}, 8'h00);
  endtask : t_reset_values

  task automatic t_wave_irq;
    rd_chk(irq_flags_pkg::FLAGS_FOUR_OFS, 8'h00);
    wr_reg(irq_flags_pkg::MASK_FOUR_OFS, 8'h40);
    fire('{waveform_shutdown: 1'b1, default: 1'b0});
    check8(flags_four, 8'h40);
    check8({7'h00, irq}, 8'h01);
    rd_chk(irq_flags_pkg::STATUS_FOUR_OFS, 8'h40);
    check8({7'h00, irq}, 8'h00);
    check8(flags_four, 8'h40);
    wr_reg(irq_flags_pkg::FLAGS_FOUR_OFS, 8'h00);
    repeat (5) @(posedge clk_i);
    #1;
    check8(flags_four, 8'h00);
    wr_reg(irq_flags_pkg::MASK_FOUR_OFS, 8'h00);
  endtask : t_wave_irq

  task automatic t_modes;
    irq_flags_pkg::periph_events_type e;
    logic [7:0]                       exp;
    for (int m = 0; m < 4; m++) begin
      wr_reg(irq_flags_pkg::CAPCMP_MODE_OFS, {4'h0, m[1:0], m[1:0]});
      for (int k = 0; k < 3; k++) begin
        e = '0;
        e.capcmp1_capture  = (k == 0);
        e.capcmp2_capture  = (k == 0);
        e.capcmp1_compare  = (k == 1);
        e.capcmp2_compare  = (k == 1);
        e.capcmp1_pwm_edge = (k == 2);
        e.capcmp2_pwm_edge = (k == 2);
        exp = (k == m) ? 8'h03 : 8'h00;
        fire(e);
        check8(flags_four, exp);
        rd_chk(irq_flags_pkg::STATUS_FOUR_OFS, exp);
        wr_reg(irq_flags_pkg::FLAGS_FOUR_OFS, 8'h00);
      end
    end
    wr_reg(irq_flags_pkg::CAPCMP_MODE_OFS, 8'h00);
  endtask : t_modes

  task automatic t_flags_three;
    fire('{osc_fail: 1'b1, default: 1'b0});
    check8(flags_three, 8'h80);
    fire('{clock_switch_done: 1'b1, default: 1'b0});
    check8(flags_three, 8'hC0);
    fire('{logic_cell1_output: 1'b1, default: 1'b0});
    check8(flags_three, 8'hC1);
    fire('{logic_cell2_output: 1'b1, default: 1'b0});
    check8(flags_three, 8'hC3);
    rd_chk(irq_flags_pkg::FLAGS_THREE_OFS, 8'hC3);
    rd_chk(irq_flags_pkg::STATUS_THREE_OFS, 8'hC3);
    rd_chk(irq_flags_pkg::STATUS_THREE_OFS, 8'h00);
    wr_reg(irq_flags_pkg::FLAGS_THREE_OFS, 8'h00);
    check8(flags_three, 8'h00);
    wr_reg(irq_flags_pkg::FLAGS_THREE_OFS, 8'hFF);
    rd_chk(irq_flags_pkg::FLAGS_THREE_OFS, 8'hC3);
    wr_reg(irq_flags_pkg::FLAGS_FOUR_OFS, 8'hFF);
    rd_chk(irq_flags_pkg::FLAGS_FOUR_OFS, 8'h43);
    wr_reg(irq_flags_pkg::FLAGS_THREE_OFS, 8'h3C);
    check8(flags_three, 8'h00);
  endtask : t_flags_three

  task automatic t_cell_edges;
    wr_reg(irq_flags_pkg::CELL_EDGE_OFS, 8'h00);
    fire('{logic_cell1_output: 1'b1, logic_cell2_output: 1'b1, default: 1'b0});
    check8(flags_three, 8'h00);
    rd_chk(irq_flags_pkg::STATUS_THREE_OFS, 8'h00);
    wr_reg(irq_flags_pkg::CELL_EDGE_OFS, 8'h0A);
    rd_chk(irq_flags_pkg::CELL_EDGE_OFS, 8'h0A);
    fire('{logic_cell1_output: 1'b1, logic_cell2_output: 1'b1, default: 1'b0});
    check8(flags_three, 8'h03);
    rd_chk(irq_flags_pkg::STATUS_THREE_OFS, 8'h03);
    wr_reg(irq_flags_pkg::CELL_EDGE_OFS, 8'h05);
    wr_reg(irq_flags_pkg::FLAGS_THREE_OFS, 8'h00);
  endtask : t_cell_edges

  task automatic t_mid_reset;
    fire('{osc_fail: 1'b1, default: 1'b0});
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check8(flags_four, 8'h00);
    rd_chk(irq_flags_pkg::FLAGS_THREE_OFS, 8'h00);
    rd_chk(irq_flags_pkg::STATUS_THREE_OFS, 8'h00);
  endtask : t_mid_reset

  // ----------------------------------------------------------------
  // hang guard and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      end_sim;
    end
  end

  initial begin
    reset_i     = 1'b1;
    bus_q       = '0;
    request_q   = '0;
    num_errors  = 0;
    check_count = 0;
    cycles      = 0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset_values;
    t_wave_irq;
    t_modes;
    t_flags_three;
    t_cell_edges;
    t_mid_reset;
    end_sim;
  end
endmodule : tb_top
